// ---- hdl/flash_sector_protection_ctrl.sv ----
`timescale 1ns/1ns
// Function
// - Sectors 0 and 1 are fixed 4 KB blocks.
// - Sector 0 sits at F000h-FFFFh and holds the vectors.
// - 4 KB has sector 0, 8 KB sectors 0-1, larger sectors 0-2.
// - Erasing one sector leaves every other sector untouched.
// - Programming is per byte; erase per sector or whole array.
// - In application programming refuses sector 0 program and erase.
// - Circuit or tool mode may program or erase all, option byte too.
// - Readout protection blocks external reads and flash writes.
// - Removing protection first erases the whole program memory.
// - Option byte bit turns readout protection on or off.
// - Link clock and data pins are taken from the application when attached.
// - Control/status register runs program/erase and resets to 00h.
module flash_sector_protection_ctrl
    import flash_prot_pkg::*;
#(
    parameter int FLASH_KB = FLASH_KB_DEF
) (
    input  wire logic        I_CLK,
    input  wire logic        I_SYS_RST,
    input  wire logic        i_PSEL,
    input  wire logic        i_PENABLE,
    input  wire logic        i_PWRITE,
    input  wire logic [7:0]  i_PADDR,
    input  wire logic [31:0] i_PWDATA,
    output logic      [31:0] o_PRDATA,
    output logic             o_PREADY,
    output logic             o_PSLVERR,
    input  wire logic        i_INCIRCUIT_COMM_MODE,
    input  wire logic        i_TOOL_MODE,
    input  wire logic        i_TOOL_ATTACHED,
    input  wire logic [7:0]  i_OPTION_BYTE,
    input  wire logic        i_EXT_READ_REQ,
    output logic             o_EXT_READ_OK,
    output logic      [15:0] o_FL_ADDR,
    output logic      [7:0]  o_FL_WDATA,
    output logic             o_FL_PROG,
    output logic             o_FL_ERASE,
    output logic      [2:0]  o_FL_SECT_MASK,
    output logic             o_OPT_WRITE,
    input  wire logic        i_FL_BUSY,
    input  wire logic [1:0]  i_APP_PIN_OUT,
    input  wire logic [1:0]  i_APP_PIN_OE_N,
    output logic      [1:0]  o_APP_PIN_IN,
    input  wire logic [1:0]  i_PIN_IN,
    output logic      [1:0]  o_PIN_OUT,
    output logic      [1:0]  o_PIN_OE_N
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_ISSUE = 5'b00010,
        S_ARM   = 5'b00100,
        S_WAIT  = 5'b01000,
        S_OPT   = 5'b10000
    } fsm_t;

    typedef struct packed {
        fsm_t        fsm;
        logic [15:0] addr;
        logic [7:0]  data;
        logic [7:0]  option;
        logic [7:0]  opt_pend;
        logic        opt_after;
        logic        opt_loaded;
        logic        refused;
        logic        done;
        op_t         op;
        logic [2:0]  mask;
        logic [31:0] prdata;
        logic        slverr;
        logic        fl_prog;
        logic        fl_erase;
        logic        opt_we;
        logic        read_ok;
        logic [1:0]  app_in;
        logic [1:0]  pin_out;
        logic [1:0]  pin_oe_n;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic       prog_mode;
    logic       rdp;
    logic [2:0] addr_mask;
    logic       addr_in;
    logic       allowed;
    op_t        req_op;
    logic       wr_acc;
    logic       rd_setup;
    logic       mapped;
    logic [1:0] pin_out_d;
    logic [1:0] pin_oe_n_d;
    logic [1:0] app_in_d;
    logic [2:0] all_mask;

    assign prog_mode = i_INCIRCUIT_COMM_MODE | i_TOOL_MODE;
    assign rdp = cur.option[BIT_RDP];

    assign all_mask = (FLASH_KB <= 4) ? 3'b001 :
                      (FLASH_KB <= 8) ? 3'b011 : 3'b111;

    // ------------------------------------------------------------------
    // Sector lookup and permission
    // ------------------------------------------------------------------
    // fixed sector decode
    sector_decode #(
        .FLASH_KB    (FLASH_KB)
    ) u_decode (
        .i_addr      (cur.addr),
        .o_sect_mask (addr_mask),
        .o_in_array  (addr_in)
    );

    always_comb begin
        if (i_PWDATA[BIT_MERASE]) begin
            req_op = OP_MERASE;
        end else if (i_PWDATA[BIT_SERASE]) begin
            req_op = OP_SERASE;
        end else begin
            req_op = OP_PROG;
        end
    end

    op_permit u_permit (
        .i_prog_mode (prog_mode),
        .i_rdp       (rdp),
        .i_op        (req_op),
        .i_sect_mask (addr_mask),
        .i_in_array  (addr_in),
        .o_allowed   (allowed)
    );

    // ------------------------------------------------------------------
    // Link pins
    // ------------------------------------------------------------------
    // The tool drives these pins through its own port; the application
    // only loses them, so its inputs see zero rather than tool traffic.
    generate
        for (genvar p = 0; p < 2; p++) begin : g_pin
            assign pin_oe_n_d[p] = i_TOOL_ATTACHED | i_APP_PIN_OE_N[p];
            assign pin_out_d[p]  = i_TOOL_ATTACHED ? 1'b0
                                                   : i_APP_PIN_OUT[p];
            assign app_in_d[p]   = i_TOOL_ATTACHED ? 1'b0 : i_PIN_IN[p];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    assign wr_acc   = i_PSEL & i_PENABLE & i_PWRITE;
    assign rd_setup = i_PSEL & ~i_PENABLE;
    assign mapped   = (i_PADDR == OFF_CTRL) | (i_PADDR == OFF_ADDR) |
                      (i_PADDR == OFF_DATA) | (i_PADDR == OFF_OPT);

    always_comb begin
        next_cur          = cur;
        next_cur.fl_prog  = 1'b0;
        next_cur.fl_erase = 1'b0;
        next_cur.opt_we   = 1'b0;
        next_cur.pin_out  = pin_out_d;
        next_cur.pin_oe_n = pin_oe_n_d;
        next_cur.app_in   = app_in_d;
        next_cur.read_ok  = i_EXT_READ_REQ & ~rdp;

        // Option byte is caught once, on the first edge after reset.
        if (!cur.opt_loaded) begin
            next_cur.option     = i_OPTION_BYTE;
            next_cur.opt_loaded = 1'b1;
        end

        // Read data is captured in the setup cycle so it leaves a flop.
        if (rd_setup) begin
            next_cur.slverr = ~mapped;
            case (i_PADDR)
                OFF_CTRL: begin
                    next_cur.prdata = 32'h0;
                    next_cur.prdata[BIT_BUSY]    = cur.fsm != S_IDLE;
                    next_cur.prdata[BIT_REFUSED] = cur.refused;
                    next_cur.prdata[BIT_DONE]    = cur.done;
                end
                OFF_ADDR: next_cur.prdata = {16'h0, cur.addr};
                OFF_DATA: next_cur.prdata = {24'h0, cur.data};
                OFF_OPT:  next_cur.prdata = {24'h0, cur.option};
                default:  next_cur.prdata = 32'h0;
            endcase
        end

        // Status flags clear by writing one; a new event wins below.
        if (wr_acc && i_PADDR == OFF_CTRL) begin
            if (i_PWDATA[BIT_REFUSED]) begin
                next_cur.refused = 1'b0;
            end
            if (i_PWDATA[BIT_DONE]) begin
                next_cur.done = 1'b0;
            end
        end

        // Target and data are frozen while an operation runs.
        if (wr_acc && cur.fsm == S_IDLE) begin
            if (i_PADDR == OFF_ADDR) begin
                next_cur.addr = i_PWDATA[15:0];
            end
            if (i_PADDR == OFF_DATA) begin
                next_cur.data = i_PWDATA[7:0];
            end
        end

        case (cur.fsm)
            S_IDLE: begin
                if (wr_acc && i_PADDR == OFF_CTRL) begin
                    if (i_PWDATA[BIT_OPTW]) begin
                        if (!prog_mode) begin
                            next_cur.refused = 1'b1;
                        end else begin
                            next_cur.opt_pend = i_PWDATA[7:0];
                            if (rdp && !i_PWDATA[BIT_RDP]) begin
                                next_cur.op        = OP_MERASE;
                                next_cur.mask      = all_mask;
                                next_cur.opt_after = 1'b1;
                                next_cur.fsm       = S_ISSUE;
                            end else begin
                                next_cur.fsm = S_OPT;
                            end
                        end
                    end else if (|i_PWDATA[BIT_MERASE:BIT_PROG]) begin
                        if (!allowed) begin
                            next_cur.refused = 1'b1;
                        end else begin
                            next_cur.op  = req_op;
                            next_cur.mask = (req_op == OP_MERASE) ?
                                            all_mask : addr_mask;
                            next_cur.fsm = S_ISSUE;
                        end
                    end
                end
            end
            S_ISSUE: begin
                next_cur.fl_prog  = cur.op == OP_PROG;
                next_cur.fl_erase = cur.op != OP_PROG;
                next_cur.fsm      = S_ARM;
            end
            S_ARM: begin
                next_cur.fsm = S_WAIT;
            end
            S_WAIT: begin
                if (!i_FL_BUSY) begin
                    if (cur.opt_after) begin
                        next_cur.opt_after = 1'b0;
                        next_cur.fsm       = S_OPT;
                    end else begin
                        next_cur.done = 1'b1;
                        next_cur.fsm  = S_IDLE;
                    end
                end
            end
            S_OPT: begin
                next_cur.opt_we = 1'b1;
                next_cur.option = cur.opt_pend;
                next_cur.done   = 1'b1;
                next_cur.fsm    = S_IDLE;
            end
            default: begin
                next_cur.fsm = S_IDLE;
            end
        endcase

        // Requests that arrive while busy are refused, never queued.
        if (wr_acc && i_PADDR == OFF_CTRL && cur.fsm != S_IDLE &&
            |i_PWDATA[BIT_OPTW:BIT_PROG]) begin
            next_cur.refused = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            cur            <= '0;
            cur.fsm        <= S_IDLE;
            cur.op         <= OP_PROG;
            cur.option     <= OPT_RESET;
            cur.pin_oe_n   <= 2'b11;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Zero wait states: data was prepared during the setup cycle.
    assign o_PREADY       = 1'b1;
    assign o_PRDATA       = cur.prdata;
    assign o_PSLVERR      = i_PSEL & i_PENABLE & cur.slverr;
    assign o_EXT_READ_OK  = cur.read_ok;
    assign o_FL_ADDR      = cur.addr;
    assign o_FL_WDATA     = cur.data;
    assign o_FL_PROG      = cur.fl_prog;
    assign o_FL_ERASE     = cur.fl_erase;
    assign o_FL_SECT_MASK = cur.mask;
    assign o_OPT_WRITE    = cur.opt_we;
    assign o_APP_PIN_IN   = cur.app_in;
    assign o_PIN_OUT      = cur.pin_out;
    assign o_PIN_OE_N     = cur.pin_oe_n;

endmodule

// ---- include/flash_prot_pkg.sv ----
package flash_prot_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses on the APB word grid
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_OPT  = 8'h0c;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] OPT_RESET  = 8'h00;

    // Fields of the control/status register.
    localparam int BIT_PROG    = 0;
    localparam int BIT_SERASE  = 1;
    localparam int BIT_MERASE  = 2;
    localparam int BIT_OPTW    = 3;
    localparam int BIT_BUSY    = 5;
    localparam int BIT_REFUSED = 6;
    localparam int BIT_DONE    = 7;

    // Readout protection bit inside the option byte, high means protected.
    localparam int BIT_RDP = 0;

    // ------------------------------------------------------------------
    // Sector map
    // ------------------------------------------------------------------
    localparam int              NUM_SECTORS  = 3;
    localparam int              SECTOR_BYTES = 4096;
    localparam logic [16:0]     SPACE_TOP    = 17'h10000;
    localparam logic [15:0]     SECT0_BASE   = 16'hf000;
    localparam logic [15:0]     SECT1_BASE   = 16'he000;
    localparam int              FLASH_KB_DEF = 32;

    typedef enum logic [2:0] {
        OP_PROG   = 3'b001,
        OP_SERASE = 3'b010,
        OP_MERASE = 3'b100
    } op_t;

endpackage

// ---- hdl/sector_decode.sv ----
`timescale 1ns/1ns
module sector_decode
    import flash_prot_pkg::*;
#(
    parameter int FLASH_KB = FLASH_KB_DEF
) (
    input  wire logic [15:0] i_addr,
    output logic      [2:0]  o_sect_mask,
    output logic             o_in_array
);
    localparam logic [16:0] BASE =
        17'(SPACE_TOP - 17'(FLASH_KB * 1024));

    // Sector 2 takes whatever lies below the two fixed 4 KB sectors.
    always_comb begin
        o_in_array = {1'b0, i_addr} >= BASE;
        if (i_addr >= SECT0_BASE) begin
            o_sect_mask = 3'b001;
        end else if (i_addr >= SECT1_BASE) begin
            o_sect_mask = 3'b010;
        end else begin
            o_sect_mask = 3'b100;
        end
    end
endmodule

// ---- hdl/op_permit.sv ----
`timescale 1ns/1ns
module op_permit
    import flash_prot_pkg::*;
(
    input  wire logic       i_prog_mode,
    input  wire logic       i_rdp,
    input  wire op_t        i_op,
    input  wire logic [2:0] i_sect_mask,
    input  wire logic       i_in_array,
    output logic            o_allowed
);
    always_comb begin
        o_allowed = 1'b1;
        if (i_rdp) begin
            o_allowed = 1'b0;
        end
        if (!i_prog_mode && i_op != OP_MERASE && i_sect_mask[0]) begin
            o_allowed = 1'b0;
        end
        if (!i_prog_mode && i_op == OP_MERASE) begin
            o_allowed = 1'b0;
        end
        if (i_op != OP_MERASE && !i_in_array) begin
            o_allowed = 1'b0;
        end
    end
endmodule

// ---- dv/flash_sector_protection_ctrl_props.sv ----
`timescale 1ns/1ns
module flash_sector_protection_ctrl_props
    import flash_prot_pkg::*;
#(
    parameter int FLASH_KB = FLASH_KB_DEF
) (
    input wire logic        I_CLK,
    input wire logic        I_SYS_RST,
    input wire logic        i_PSEL,
    input wire logic        i_PENABLE,
    input wire logic [7:0]  i_PADDR,
    input wire logic        o_PREADY,
    input wire logic        o_PSLVERR,
    input wire logic        i_INCIRCUIT_COMM_MODE,
    input wire logic        i_TOOL_MODE,
    input wire logic        i_TOOL_ATTACHED,
    input wire logic        i_EXT_READ_REQ,
    input wire logic        o_EXT_READ_OK,
    input wire logic [15:0] o_FL_ADDR,
    input wire logic        o_FL_PROG,
    input wire logic        o_FL_ERASE,
    input wire logic [2:0]  o_FL_SECT_MASK,
    input wire logic        i_FL_BUSY,
    input wire logic [1:0]  o_APP_PIN_IN,
    input wire logic [1:0]  o_PIN_OUT,
    input wire logic [1:0]  o_PIN_OE_N
);
    localparam logic [2:0] PRESENT = (FLASH_KB <= 4) ? 3'h1 :
                                     (FLASH_KB <= 8) ? 3'h3 : 3'h7;
    logic app_mode;
    logic acc;
    logic mapped;
    assign app_mode = !i_INCIRCUIT_COMM_MODE && !i_TOOL_MODE;
    assign acc = i_PSEL && i_PENABLE;
    assign mapped = i_PADDR inside {OFF_CTRL, OFF_ADDR, OFF_DATA, OFF_OPT};
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    property p_ready; o_PREADY; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_err_bad; acc && !mapped |-> o_PSLVERR; endproperty
    a_err_bad: assert property (p_err_bad) else $error("no slave error");
    property p_err_ok; acc && mapped |-> !o_PSLVERR; endproperty
    a_err_ok: assert property (p_err_ok) else $error("false slave error");
    property p_prog_pulse; o_FL_PROG |=> !o_FL_PROG; endproperty
    a_prog_pulse: assert property (p_prog_pulse) else $error("long pulse");
    property p_no_overlap;
        o_FL_PROG || o_FL_ERASE |-> !i_FL_BUSY && !(o_FL_PROG && o_FL_ERASE);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("overlap");
    property p_app_prog; app_mode && o_FL_PROG |-> o_FL_ADDR[15:12] != 4'hf;
    endproperty
    a_app_prog: assert property (p_app_prog) else $error("boot write");
    property p_app_erase; app_mode && o_FL_ERASE |-> !o_FL_SECT_MASK[0];
    endproperty
    a_app_erase: assert property (p_app_erase) else $error("boot erase");
    property p_present; o_FL_ERASE |-> (o_FL_SECT_MASK & ~PRESENT) == 3'h0;
    endproperty
    a_present: assert property (p_present) else $error("absent sector");
    property p_tool_pins;
        $past(i_TOOL_ATTACHED) |->
            o_PIN_OE_N == 2'h3 && o_PIN_OUT == 2'h0 && o_APP_PIN_IN == 2'h0;
    endproperty
    a_tool_pins: assert property (p_tool_pins) else $error("pins leak");
    property p_ext_read; o_EXT_READ_OK |-> $past(i_EXT_READ_REQ); endproperty
    a_ext_read: assert property (p_ext_read) else $error("stray read");
endmodule

bind flash_sector_protection_ctrl flash_sector_protection_ctrl_props #(
    .FLASH_KB(FLASH_KB)
) i_props (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_PSEL(i_PSEL),
    .i_PENABLE(i_PENABLE), .i_PADDR(i_PADDR), .o_PREADY(o_PREADY),
    .o_PSLVERR(o_PSLVERR), .i_INCIRCUIT_COMM_MODE(i_INCIRCUIT_COMM_MODE),
    .i_TOOL_MODE(i_TOOL_MODE), .i_TOOL_ATTACHED(i_TOOL_ATTACHED),
    .i_EXT_READ_REQ(i_EXT_READ_REQ), .o_EXT_READ_OK(o_EXT_READ_OK),
    .o_FL_ADDR(o_FL_ADDR), .o_FL_PROG(o_FL_PROG), .o_FL_ERASE(o_FL_ERASE),
    .o_FL_SECT_MASK(o_FL_SECT_MASK), .i_FL_BUSY(i_FL_BUSY),
    .o_APP_PIN_IN(o_APP_PIN_IN), .o_PIN_OUT(o_PIN_OUT),
    .o_PIN_OE_N(o_PIN_OE_N)
);

// ---- dv/flash_model.sv ----
`timescale 1ns/1ns
module flash_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_prog,
    input  wire logic        i_erase,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic [2:0]  i_mask,
    output logic             o_busy
);
    // Busy length is a variable so the bench can make the array slow.
    int         busy_cyc = 3;
    int         left;
    logic [7:0] mem [0:65535];

    // An unwritten array reads as erased.
    initial begin
        for (int k = 0; k < 65536; k++)
            mem[k] = 8'hff;
    end

    function automatic int sector_of(input int a);
        return (a >= 32'hf000) ? 0 : (a >= 32'he000) ? 1 : 2;
    endfunction

    function automatic logic [7:0] rd(input logic [15:0] a);
        return mem[a];
    endfunction

    always @(posedge i_clk) begin
        if (i_rst) begin
            left = 0;
            o_busy <= 1'b0;
        end else begin
            if (left > 0)
                left--;
            if (i_prog) begin
                mem[i_addr] = rd(i_addr) & i_wdata;
                left = busy_cyc;
            end
            if (i_erase) begin
                for (int k = 0; k < 65536; k++)
                    if (i_mask[sector_of(k)])
                        mem[k] = 8'hff;
                left = busy_cyc;
            end
            o_busy <= left > 0;
        end
    end
endmodule

// ---- dv/flash_sector_protection_ctrl_tb.sv ----
`timescale 1ns/1ns
module flash_sector_protection_ctrl_tb
    import flash_prot_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst, psel, penable, pwrite, comm_mode, tool, attached, xreq;
    logic        pready, pslverr, xok, fl_prog, fl_erase, opt_wr, fl_busy;
    logic [7:0]  paddr, optb, fl_wdata;
    logic [15:0] fl_addr;
    logic [2:0]  fl_mask;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  app_out, app_oe_n, app_in, pin_in, pin_out, pin_oe_n;
    int          miscompares = 0;
    int          n_compared = 0;
    int          n_optw = 0;

    always #20 clk = ~clk;

    flash_sector_protection_ctrl i_dut (
        .I_CLK(clk), .I_SYS_RST(rst), .i_PSEL(psel), .i_PENABLE(penable),
        .i_PWRITE(pwrite), .i_PADDR(paddr), .i_PWDATA(pwdata),
        .o_PRDATA(prdata), .o_PREADY(pready), .o_PSLVERR(pslverr),
        .i_INCIRCUIT_COMM_MODE(comm_mode), .i_TOOL_MODE(tool),
        .i_TOOL_ATTACHED(attached), .i_OPTION_BYTE(optb),
        .i_EXT_READ_REQ(xreq), .o_EXT_READ_OK(xok), .o_FL_ADDR(fl_addr),
        .o_FL_WDATA(fl_wdata), .o_FL_PROG(fl_prog), .o_FL_ERASE(fl_erase),
        .o_FL_SECT_MASK(fl_mask), .o_OPT_WRITE(opt_wr), .i_FL_BUSY(fl_busy),
        .i_APP_PIN_OUT(app_out), .i_APP_PIN_OE_N(app_oe_n),
        .o_APP_PIN_IN(app_in), .i_PIN_IN(pin_in), .o_PIN_OUT(pin_out),
        .o_PIN_OE_N(pin_oe_n)
    );

    flash_model i_flash (
        .i_clk(clk), .i_rst(rst), .i_prog(fl_prog), .i_erase(fl_erase),
        .i_addr(fl_addr), .i_wdata(fl_wdata), .i_mask(fl_mask),
        .o_busy(fl_busy)
    );

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Starts a command, polls until idle, checks done/refused, clears them.
    task automatic op(input logic [31:0] cmd, input logic [1:0] m,
                      input logic [1:0] e);
        apb(1'b1, OFF_CTRL, cmd);
        do begin
            apb(1'b0, OFF_CTRL, 32'h0);
        end while (r[BIT_BUSY] !== 1'b0);
        chk({30'h0, r[BIT_DONE], r[BIT_REFUSED]} & {30'h0, m}, {30'h0, e});
        apb(1'b1, OFF_CTRL, 32'hc0);
    endtask

    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, OFF_ADDR, {16'h0, a});
        apb(1'b1, OFF_DATA, {24'h0, d});
    endtask

    task automatic mchk(input logic [15:0] a, input logic [7:0] e);
        chk({24'h0, i_flash.rd(a)}, {24'h0, e});
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    // Counts option byte write pulses, each lasts one cycle.
    always @(posedge clk) begin
        if (opt_wr === 1'b1)
            n_optw++;
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, comm_mode, tool, attached, xreq} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        optb = 8'h0;
        app_out = 2'h0;
        app_oe_n = 2'h3;
        pin_in = 2'h3;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, OFF_OPT, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0);
        $display("test reset done");
        prog(16'he010, 8'h5a);
        op(32'h1, 2'h3, 2'h2);
        mchk(16'he010, 8'h5a);
        prog(16'hc020, 8'h33);
        op(32'h1, 2'h3, 2'h2);
        prog(16'hf010, 8'h77);
        op(32'h1, 2'h1, 2'h1);
        mchk(16'hf010, 8'hff);
        op(32'h2, 2'h1, 2'h1);
        op(32'h4, 2'h1, 2'h1);
        prog(16'he000, 8'h0);
        op(32'h2, 2'h3, 2'h2);
        mchk(16'he010, 8'hff);
        mchk(16'hc020, 8'h33);
        i_flash.busy_cyc = 20;
        prog(16'hc021, 8'h44);
        apb(1'b1, OFF_CTRL, 32'h1);
        op(32'h1, 2'h3, 2'h3);
        mchk(16'hc021, 8'h44);
        i_flash.busy_cyc = 3;
        $display("test application done");
        for (int m = 0; m < 2; m++) begin
            comm_mode <= (m == 0);
            tool <= (m == 1);
            prog(16'hf010 + 16'(m), 8'ha5);
            op(32'h1, 2'h3, 2'h2);
            mchk(16'hf010 + 16'(m), 8'ha5);
        end
        prog(16'hefff, 8'h11);
        op(32'h1, 2'h3, 2'h2);
        prog(16'hffff, 8'h0);
        op(32'h2, 2'h3, 2'h2);
        mchk(16'hf010, 8'hff);
        mchk(16'hefff, 8'h11);
        $display("test programming done");
        op(32'h9, 2'h1, 2'h0);
        apb(1'b0, OFF_OPT, 32'h0);
        chk(r, 32'h9);
        xreq <= 1'b1;
        repeat (3) @(negedge clk);
        chk({31'h0, xok}, 32'h0);
        prog(16'hc030, 8'h0);
        op(32'h1, 2'h1, 2'h1);
        op(32'h8, 2'h3, 2'h2);
        mchk(16'hc020, 8'hff);
        mchk(16'hefff, 8'hff);
        apb(1'b0, OFF_OPT, 32'h0);
        chk(r, 32'h8);
        chk(n_optw, 32'h2);
        repeat (2) @(negedge clk);
        chk({31'h0, xok}, 32'h1);
        @(posedge clk);
        xreq <= 1'b0;
        $display("test protection done");
        attached <= 1'b1;
        app_out <= 2'h3;
        app_oe_n <= 2'h0;
        repeat (2) @(negedge clk);
        chk({26'h0, pin_oe_n, pin_out, app_in}, 32'h30);
        @(posedge clk);
        attached <= 1'b0;
        repeat (2) @(negedge clk);
        chk({26'h0, pin_oe_n, pin_out, app_in}, 32'hf);
        $display("test pins done");
        stop_test();
    end
endmodule
